// *** ubrk_channel_a.v ***
// Functional notes
// - Break address is 32 bits in two 16-bit halves, high 31..16, low 15..0.
// - Power-on reset clears address and mask halves; manual reset keeps their contents.
// - Each mask bit pairs with the address bit at the same position.
// - Mask bit 0 compares that address bit; mask bit 1 ignores it.
// - Filter bits 15..8 read zero; software writes zero there.
// - Master field: 00 off, 01 processor, 10 DMA, 11 any master.
// - Fetch/data field: 00 off, 01 fetch, 10 data, 11 either.
// - Direction field: 00 off, 01 read, 10 write, 11 either.
// - Size field: 00 any size, 01 byte, 10 word, 11 longword.
// - Any of master, fetch or direction at 00 blocks all breaks.
// - Instruction fetches count as word size for matching.
// - Data accesses use the access operand size, not target bus width.
// - Filter register clears on power-on reset; kept through manual reset.
// - A met condition raises a user break interrupt request.
// - Comparison works on cache, internal DMA and X/Y bus cycles.
`timescale 1ns/1ns
`default_nettype none
`include "ubrk_defs.vh"
module ubrk_channel_a (
  input wire clock, // System clock, 10 MHz
  input wire rst_n, // Power-on reset, async
  input wire manual_rst_n, // Manual reset, registers kept
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [3:0] pstrb, // APB byte strobes
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error
  input wire cyc_valid, // Bus cycle present
  input wire [31:0] cyc_addr, // Bus cycle address
  input wire cyc_is_dma, // Cycle by DMA or Ethernet DMA
  input wire cyc_is_fetch, // Instruction fetch cycle
  input wire cyc_is_write, // Write cycle
  input wire [1:0] cyc_size, // Access operand size
  output reg break_match, // Match pulse, registered
  output reg break_irq // User break request level
);
  reg [15:0] break_addr_a_high;
  reg [15:0] break_addr_a_low;
  reg [15:0] break_addr_mask_a_high;
  reg [15:0] break_addr_mask_a_low;
  reg [7:0] break_cycle_filter_a;
  reg [15:0] next_break_addr_a_high;
  reg [15:0] next_break_addr_a_low;
  reg [15:0] next_break_addr_mask_a_high;
  reg [15:0] next_break_addr_mask_a_low;
  reg [7:0] next_break_cycle_filter_a;
  reg [31:0] next_prdata;
  reg next_break_irq;

  wire [31:0] break_addr_a;
  wire [31:0] break_addr_mask_a;
  wire [1:0] master_sel;
  wire [1:0] fetch_sel;
  wire [1:0] dir_sel;
  wire [1:0] size_sel;
  wire [1:0] eff_size;
  wire addr_hit;
  wire master_hit;
  wire fetch_hit;
  wire dir_hit;
  wire size_hit;
  wire enabled;
  wire match_allowed;
  wire next_match;

  wire access;
  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire sel_addr_high;
  wire sel_addr_low;
  wire sel_mask_high;
  wire sel_mask_low;
  wire sel_filter;
  wire sel_status;
  wire wr_addr_high;
  wire wr_addr_low;
  wire wr_mask_high;
  wire wr_mask_low;
  wire wr_filter;
  wire irq_clear;
  wire [15:0] wr_half;
  wire [1:0] wr_lanes;
  wire [31:0] status_word;

  // Two-bit select: bit 0 picks the first case, bit 1 the second
  function sel_hit;
    input [1:0] sel;
    input second;
    begin
      sel_hit = second ? sel[1] : sel[0];
    end
  endfunction

  // Byte-lane merge of one 16-bit half
  function [15:0] merge_half;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] strb;
    begin
      merge_half = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
    end
  endfunction

  // Register offset decode
  function offset_is;
    input [11:0] addr;
    input [11:0] offset;
    begin
      offset_is = (addr == offset);
    end
  endfunction

  // Size filter: 00 takes any size, else sizes must agree
  function size_ok;
    input [1:0] sel;
    input [1:0] size;
    begin
      size_ok = (sel == `UBRK_SIZE_ANY) || (sel == size);
    end
  endfunction

  assign break_addr_a = {break_addr_a_high, break_addr_a_low};
  assign break_addr_mask_a = {break_addr_mask_a_high, break_addr_mask_a_low};
  assign master_sel = break_cycle_filter_a[`UBRK_MASTER_MSB:`UBRK_MASTER_LSB];
  assign fetch_sel = break_cycle_filter_a[`UBRK_FETCH_MSB:`UBRK_FETCH_LSB];
  assign dir_sel = break_cycle_filter_a[`UBRK_DIR_MSB:`UBRK_DIR_LSB];
  assign size_sel = break_cycle_filter_a[`UBRK_SIZE_MSB:`UBRK_SIZE_LSB];

  // Full 32-bit masked compare on any bus the cycle came from
  assign addr_hit = ((cyc_addr ^ break_addr_a) & ~break_addr_mask_a) == 32'h0000_0000;
  assign eff_size = cyc_is_fetch ? `UBRK_SIZE_WORD : cyc_size;
  assign master_hit = sel_hit(master_sel, cyc_is_dma);
  assign fetch_hit = sel_hit(fetch_sel, ~cyc_is_fetch);
  assign dir_hit = sel_hit(dir_sel, cyc_is_write);
  assign size_hit = size_ok(size_sel, eff_size);
  assign enabled = (master_sel != 2'h0) && (fetch_sel != 2'h0) && (dir_sel != 2'h0);
  assign match_allowed = enabled && manual_rst_n;
  assign next_match = cyc_valid && match_allowed && addr_hit
    && master_hit && fetch_hit && dir_hit && size_hit;

  // APB decode, zero wait states
  assign sel_addr_high = offset_is(paddr, `UBRK_OFF_ADDR_HIGH);
  assign sel_addr_low = offset_is(paddr, `UBRK_OFF_ADDR_LOW);
  assign sel_mask_high = offset_is(paddr, `UBRK_OFF_MASK_HIGH);
  assign sel_mask_low = offset_is(paddr, `UBRK_OFF_MASK_LOW);
  assign sel_filter = offset_is(paddr, `UBRK_OFF_FILTER);
  assign sel_status = offset_is(paddr, `UBRK_OFF_STATUS);
  assign addr_ok = sel_addr_high || sel_addr_low
    || sel_mask_high || sel_mask_low
    || sel_filter || sel_status;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;
  assign wr_en = access && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign wr_addr_high = wr_en && sel_addr_high;
  assign wr_addr_low = wr_en && sel_addr_low;
  assign wr_mask_high = wr_en && sel_mask_high;
  assign wr_mask_low = wr_en && sel_mask_low;
  assign wr_filter = wr_en && sel_filter && pstrb[0];
  assign irq_clear = wr_en && sel_status && pstrb[0] && pwdata[1];
  assign wr_half = pwdata[15:0];
  assign wr_lanes = pstrb[1:0];
  assign status_word = {30'h0, break_irq, enabled};

  always @* begin
    case (paddr)
      `UBRK_OFF_ADDR_HIGH: next_prdata = {16'h0000, break_addr_a_high};
      `UBRK_OFF_ADDR_LOW: next_prdata = {16'h0000, break_addr_a_low};
      `UBRK_OFF_MASK_HIGH: next_prdata = {16'h0000, break_addr_mask_a_high};
      `UBRK_OFF_MASK_LOW: next_prdata = {16'h0000, break_addr_mask_a_low};
      `UBRK_OFF_FILTER: next_prdata = {24'h000000, break_cycle_filter_a};
      `UBRK_OFF_STATUS: next_prdata = status_word;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Next values of the software registers
  always @* begin
    next_break_addr_a_high = break_addr_a_high;
    if (wr_addr_high) begin
      next_break_addr_a_high = merge_half(break_addr_a_high, wr_half, wr_lanes);
    end
  end

  always @* begin
    next_break_addr_a_low = break_addr_a_low;
    if (wr_addr_low) begin
      next_break_addr_a_low = merge_half(break_addr_a_low, wr_half, wr_lanes);
    end
  end

  always @* begin
    next_break_addr_mask_a_high = break_addr_mask_a_high;
    if (wr_mask_high) begin
      next_break_addr_mask_a_high = merge_half(break_addr_mask_a_high, wr_half, wr_lanes);
    end
  end

  always @* begin
    next_break_addr_mask_a_low = break_addr_mask_a_low;
    if (wr_mask_low) begin
      next_break_addr_mask_a_low = merge_half(break_addr_mask_a_low, wr_half, wr_lanes);
    end
  end

  // Reserved upper bits are not stored
  always @* begin
    next_break_cycle_filter_a = break_cycle_filter_a;
    if (wr_filter) begin
      next_break_cycle_filter_a = pwdata[7:0];
    end
  end

  // Set wins over a clear in the same cycle
  always @* begin
    next_break_irq = break_irq;
    if (next_match) begin
      next_break_irq = 1'b1;
    end else if (irq_clear || !manual_rst_n) begin
      next_break_irq = 1'b0;
    end
  end

  // Manual reset gates matching and clears break_irq; contents are simply kept
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_addr_a_high <= `UBRK_RESET_HALF;
    end else begin
      break_addr_a_high <= next_break_addr_a_high;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_addr_a_low <= `UBRK_RESET_HALF;
    end else begin
      break_addr_a_low <= next_break_addr_a_low;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_addr_mask_a_high <= `UBRK_RESET_HALF;
    end else begin
      break_addr_mask_a_high <= next_break_addr_mask_a_high;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_addr_mask_a_low <= `UBRK_RESET_HALF;
    end else begin
      break_addr_mask_a_low <= next_break_addr_mask_a_low;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_cycle_filter_a <= `UBRK_RESET_FILTER;
    end else begin
      break_cycle_filter_a <= next_break_cycle_filter_a;
    end
  end

  // Read data loads in the setup phase and stands until the next read
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_match <= 1'b0;
    end else begin
      break_match <= next_match;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      break_irq <= 1'b0;
    end else begin
      break_irq <= next_break_irq;
    end
  end
endmodule
`default_nettype wire

// *** ubrk_defs.vh ***
`ifndef UBRK_DEFS_VH
`define UBRK_DEFS_VH
`define UBRK_OFF_ADDR_HIGH 12'h000
`define UBRK_OFF_ADDR_LOW 12'h004
`define UBRK_OFF_MASK_HIGH 12'h008
`define UBRK_OFF_MASK_LOW 12'h00c
`define UBRK_OFF_FILTER 12'h010
`define UBRK_OFF_STATUS 12'h014
`define UBRK_RESET_HALF 16'h0000
`define UBRK_RESET_FILTER 8'h00
`define UBRK_MASTER_MSB 7
`define UBRK_MASTER_LSB 6
`define UBRK_FETCH_MSB 5
`define UBRK_FETCH_LSB 4
`define UBRK_DIR_MSB 3
`define UBRK_DIR_LSB 2
`define UBRK_SIZE_MSB 1
`define UBRK_SIZE_LSB 0
`define UBRK_SIZE_ANY 2'h0
`define UBRK_SIZE_BYTE 2'h1
`define UBRK_SIZE_WORD 2'h2
`define UBRK_SIZE_LONG 2'h3
`endif

// *** bca_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module bca_checker (
  input wire clock, // Clock
  input wire rst_n, // Reset
  input wire manual_rst_n, // Manual reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire [11:0] paddr, // Address
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire cyc_valid, // Cycle present
  input wire break_match, // Match
  input wire break_irq // Request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_flag; break_match && break_irq; endsequence
  a_ready_high: assert property (pready) else $error("ready low");
  a_match_cause: assert property (break_match |-> $past(cyc_valid)) else $error("match without cycle");
  a_match_flag: assert property (break_match |-> s_flag) else $error("match without request");
  a_irq_cause: assert property ($rose(break_irq) |-> break_match) else $error("request without match");
  a_manual_quiet: assert property (!manual_rst_n |=> !break_match && !break_irq) else $error("manual");
  a_irq_sticky: assert property (break_irq && !psel && manual_rst_n |=> break_irq) else $error("lost");
  a_bad_addr: assert property (psel && penable && paddr > 12'h014 |-> pslverr) else $error("no err");
  a_good_addr:
    assert property (psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("err");
endmodule
bind ubrk_channel_a bca_checker chk_u (.clock(clock), .rst_n(rst_n), .manual_rst_n(manual_rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid),
  .break_match(break_match), .break_irq(break_irq));
`default_nettype wire

// *** bca_bus_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module bca_bus_model (
  input wire logic clock, // Clock
  output logic cyc_valid, // Cycle present
  output logic [31:0] cyc_addr, // Address
  output logic cyc_is_dma, // DMA master
  output logic cyc_is_fetch, // Fetch
  output logic cyc_is_write, // Write
  output logic [1:0] cyc_size // Operand size
);
  initial {cyc_valid, cyc_addr, cyc_is_dma, cyc_is_fetch, cyc_is_write, cyc_size} = '0;
  task run(input logic [31:0] a, input logic [4:0] k);
    @(posedge clock);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    {cyc_is_dma, cyc_is_fetch, cyc_is_write, cyc_size} <= k;
    @(posedge clock);
    cyc_valid <= 1'b0;
    cyc_addr <= ~a; // Idle bus shows no stale address
  endtask
endmodule
`default_nettype wire

// *** break_channel_a_match_setup_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module break_channel_a_match_setup_tb;
  logic clock = 0, rst_n = 0, manual_rst_n = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, cyc_addr;
  logic pready, pslverr, cyc_valid, cyc_is_dma, cyc_is_fetch, cyc_is_write, break_match, break_irq;
  logic [1:0] cyc_size;
  int fail_count = 0, checks_done = 0;
  // Filter, dma, fetch, write, size, wrong address, expected match
  logic [15:0] tbl [18] = '{16'hfc12, 16'hfc14, 16'h7c90, 16'hbc92, 16'hdc10, 16'hec12, 16'hcc10, 16'hf412,
    16'hf430, 16'hf832, 16'hf010, 16'hfd0a, 16'hfd18, 16'hfe5a, 16'hff1a, 16'hff58, 16'h3c10, 16'hdc52};
  always #50 clock = ~clock;
  ubrk_channel_a dut_u (.clock(clock), .rst_n(rst_n), .manual_rst_n(manual_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_is_dma(cyc_is_dma),
    .cyc_is_fetch(cyc_is_fetch), .cyc_is_write(cyc_is_write), .cyc_size(cyc_size), .break_match(break_match),
    .break_irq(break_irq));
  bca_bus_model bus_u (.clock(clock), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_is_dma(cyc_is_dma),
    .cyc_is_fetch(cyc_is_fetch), .cyc_is_write(cyc_is_write), .cyc_size(cyc_size));
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    fail_count++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      cmp(r, 32'h0);
      apb(1'b1, 12'(i * 4), {16'hffff, 16'h5a3c ^ 16'(i)});
      apb(1'b0, 12'(i * 4), 32'h0);
      cmp(r, {16'h0, (i == 4) ? 16'h00ff : 16'hffff} & {16'h0, 16'h5a3c ^ 16'(i)});
    end
    apb(1'b0, 12'h020, 32'h0);
    cmp(r, 32'h0);
    cmp({31'h0, e}, 32'h1);
    $display("register test done");
    apb(1'b1, 12'h000, 32'h1234);
    apb(1'b1, 12'h004, 32'h5678);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'hff);
    foreach (tbl[i]) begin
      apb(1'b1, 12'h010, {24'h0, tbl[i][15:8]});
      bus_u.run(tbl[i][2] ? 32'h1235_56aa : 32'h1234_56aa, tbl[i][7:3]);
      #1 cmp(break_match, tbl[i][1]);
      cmp(break_irq, tbl[i][1]);
      apb(1'b0, 12'h014, 32'h0);
      cmp(r, {30'h0, tbl[i][1], |tbl[i][15:14] && |tbl[i][13:12] && |tbl[i][11:10]});
      apb(1'b1, 12'h014, 32'h2);
      #1 cmp(break_irq, 1'b0);
    end
    $display("match test done");
    apb(1'b1, 12'h010, 32'hfc);
    @(posedge clock) manual_rst_n <= 1'b0;
    bus_u.run(32'h1234_5678, 5'h02);
    #1 cmp(break_match, 1'b0);
    cmp(break_irq, 1'b0);
    @(posedge clock) manual_rst_n <= 1'b1;
    bus_u.run(32'h1234_5678, 5'h02);
    #1 cmp(break_match, 1'b1);
    $display("manual reset test done");
    close_out;
  end
endmodule
`default_nettype wire
